/* pvic_pkg.sv */
package pvic_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_FOUR   = 8'h00;
  localparam logic [7:0] ADDR_FLAGS       = 8'h04;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_EVT_ENABLE  = 8'h0C;
  localparam logic [7:0] ADDR_EVT_CLEAR   = 8'h10;
  localparam logic [7:0] ADDR_SAVED_FLAGS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_PVI_ENABLE = 1;
  localparam int POS_IF         = 9;
  localparam int POS_V86        = 17;
  localparam int POS_VIF        = 19;
  localparam int POS_VIP        = 20;

  localparam int POS_EVT_GP     = 0;
  localparam int POS_EVT_DELIV  = 1;
  localparam int POS_EVT_V86_IN = 2;
  localparam int POS_EVT_V86_EX = 3;
  localparam int EVT_W          = 4;

  // ----------------------------------------------------------------
  // Levels and vectors
  // ----------------------------------------------------------------
  localparam logic [1:0] PL_USER          = 2'h3;
  localparam logic [1:0] PL_KERNEL        = 2'h0;
  localparam logic [7:0] VEC_MASKABLE_LO  = 8'h20;
  localparam logic [7:0] VEC_NMI          = 8'h02;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_PVI_ENABLE   = 1'b0;
  localparam logic       RST_IF           = 1'b0;
  localparam logic       RST_VIF          = 1'b0;
  localparam logic       RST_VIP          = 1'b0;
  localparam logic       RST_V86          = 1'b0;
  localparam logic [3:0] RST_EVT          = 4'h0;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Instruction operations from the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_CLEAR_INT = 3'b001,
    OP_SET_INT   = 3'b010,
    OP_PUSH_FLG  = 3'b011,
    OP_POP_FLG   = 3'b100,
    OP_INT_RET   = 3'b101,
    OP_CALL_PRIV = 3'b110,
    OP_TASK_SW   = 3'b111
  } pvic_op_e;

endpackage : pvic_pkg

/* pvic_ctl.sv */
// Overview of operation
// - Enabled, level 3, io level below 3: clear/set act on virtual flag only, no fault except set with virtual pending
// - Enabled mode: maskable interrupt with virtual flag clear still reaches the handler
// - Enabled mode: set with virtual pending raises a protection fault
// - Only vectors 32 to 255 are masked, by the real flag alone; NMI and exceptions unchanged
// - Not enabled mode: clear/set fault when current level exceeds io level
// - Not enabled, io level 3: clear/set change the real interrupt enable flag
// - Push, pop flags and interrupt return keep legacy behaviour in every mode
// - Virtual flag and pending are never examined unless current level is 3
// - Enabled, outside v86: privilege-changing call leaves flags untouched
// - Enter v86 only by task switch or return, leave by fault or interrupt delivery, saving flags
`timescale 1ns/1ps
`default_nettype none

module pvic_ctl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core instruction port
  input  wire logic        instr_valid_i,
  input  wire logic [2:0]  instr_op_i,
  input  wire logic [1:0]  current_privilege_level_i,
  input  wire logic [1:0]  io_privilege_level_i,
  input  wire logic [31:0] flags_load_i,
  // Interrupt request port
  input  wire logic        intr_req_i,
  input  wire logic [7:0]  intr_vector_i,
  input  wire logic        nmi_req_i,
  // Outputs
  output logic             general_protection_fault_o,
  output logic             intr_deliver_o,
  output logic      [7:0]  intr_deliver_vector_o,
  output logic             push_valid_o,
  output logic      [31:0] push_data_o,
  output logic      [31:0] flags_register_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic virt_mode(input logic protected_virtual_intr_enable, input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
    virt_mode = protected_virtual_intr_enable && (current_privilege_level == pvic_pkg::PL_USER) && (io_privilege_level != pvic_pkg::PL_USER);
  endfunction : virt_mode

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    merge_sel = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge_sel[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge_sel

  function automatic logic [31:0] pack_flags(input logic f_if, input logic f_v86,
                                             input logic f_vif, input logic f_vip);
    pack_flags = pvic_pkg::RST_WORD;
    pack_flags[pvic_pkg::POS_IF]  = f_if;
    pack_flags[pvic_pkg::POS_V86] = f_v86;
    pack_flags[pvic_pkg::POS_VIF] = f_vif;
    pack_flags[pvic_pkg::POS_VIP] = f_vip;
  endfunction : pack_flags

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                         pvi_reg;
  logic                         if_reg;
  logic                         vif_reg;
  logic                         vip_reg;
  logic                         v86_reg;
  logic [31:0]                  saved_flags_reg;
  logic [pvic_pkg::EVT_W-1:0]   evt_status_reg;
  logic [pvic_pkg::EVT_W-1:0]   evt_enable_reg;
  logic                         ack_reg;
  logic [31:0]                  rdata_reg;
  logic                         gp_reg;
  logic                         deliv_reg;
  logic [7:0]                   deliv_vec_reg;
  logic                         push_valid_reg;
  logic [31:0]                  push_data_reg;
  logic                         irq_reg;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire logic [1:0] current_privilege_level        = current_privilege_level_i;
  wire logic [1:0] io_privilege_level       = io_privilege_level_i;
  wire logic       vmode      = virt_mode(pvi_reg, current_privilege_level, io_privilege_level);
  wire logic       is_cli     = instr_valid_i && (instr_op_i == pvic_pkg::OP_CLEAR_INT);
  wire logic       is_sti     = instr_valid_i && (instr_op_i == pvic_pkg::OP_SET_INT);
  wire logic       is_push_flags_instr   = instr_valid_i && (instr_op_i == pvic_pkg::OP_PUSH_FLG);
  wire logic       is_pop_flags_instr    = instr_valid_i && (instr_op_i == pvic_pkg::OP_POP_FLG);
  wire logic       is_intr_return_instr    = instr_valid_i && (instr_op_i == pvic_pkg::OP_INT_RET);
  wire logic       is_tsw     = instr_valid_i && (instr_op_i == pvic_pkg::OP_TASK_SW);
  wire logic       cli_sti    = is_cli || is_sti;
  wire logic       user_lvl   = (current_privilege_level == pvic_pkg::PL_USER);
  // Virtual bits are only looked at from user level
  wire logic       vip_seen   = user_lvl && vip_reg;
  wire logic       legacy_ok  = (current_privilege_level <= io_privilege_level);
  wire logic       virt_gp    = vmode && is_sti && vip_seen;
  wire logic       legacy_gp  = !vmode && cli_sti && !legacy_ok;
  wire logic       gp_event   = virt_gp || legacy_gp;
  wire logic       virt_write = vmode && cli_sti && !virt_gp;
  wire logic       real_write = !vmode && cli_sti && legacy_ok;
  wire logic       intr_return_instr_sup   = is_intr_return_instr && (current_privilege_level == pvic_pkg::PL_KERNEL);
  wire logic       pop_if_ok  = (is_pop_flags_instr || is_intr_return_instr) && legacy_ok;

  // ----------------------------------------------------------------
  // Interrupt delivery
  // ----------------------------------------------------------------
  // Exceptions and NMI bypass masking; maskable vectors obey only the real flag
  wire logic       vec_mask   = (intr_vector_i >= pvic_pkg::VEC_MASKABLE_LO);
  wire logic       mask_ok    = !vec_mask || if_reg;
  wire logic       take_nmi   = nmi_req_i && !deliv_reg;
  wire logic       take_int   = intr_req_i && mask_ok && !deliv_reg && !take_nmi;
  wire logic       take_any   = take_nmi || take_int;
  wire logic [7:0] take_vec   = take_nmi ? pvic_pkg::VEC_NMI : intr_vector_i;

  // ----------------------------------------------------------------
  // Virtual-8086 entry and exit
  // ----------------------------------------------------------------
  wire logic       v86_load   = flags_load_i[pvic_pkg::POS_V86];
  wire logic       v86_enter  = !v86_reg && (is_tsw || intr_return_instr_sup) && v86_load;
  wire logic       v86_exit   = v86_reg && (gp_event || take_any);
  wire logic [31:0] cur_flags = pack_flags(if_reg, v86_reg, vif_reg, vip_reg);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic       wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic       wb_wr      = wb_req && wb_we_i;
  wire logic       wr_ctrl    = wb_wr && (wb_adr_i == pvic_pkg::ADDR_CTRL_FOUR);
  wire logic       wr_flags   = wb_wr && (wb_adr_i == pvic_pkg::ADDR_FLAGS);
  wire logic       wr_en      = wb_wr && (wb_adr_i == pvic_pkg::ADDR_EVT_ENABLE);
  wire logic       wr_clr     = wb_wr && (wb_adr_i == pvic_pkg::ADDR_EVT_CLEAR);
  wire logic [31:0] ctrl_word = pvi_reg ? (32'h0000_0001 << pvic_pkg::POS_PVI_ENABLE) : pvic_pkg::RST_WORD;
  wire logic [31:0] ctrl_new  = merge_sel(ctrl_word, wb_dat_i, wb_sel_i);
  wire logic [31:0] flags_new = merge_sel(cur_flags, wb_dat_i, wb_sel_i);
  wire logic [31:0] en_new    = merge_sel({28'h000_0000, evt_enable_reg}, wb_dat_i, wb_sel_i);
  wire logic [31:0] clr_word  = merge_sel(pvic_pkg::RST_WORD, wb_dat_i, wb_sel_i);

  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      pvic_pkg::ADDR_CTRL_FOUR:   rd_mux = ctrl_word;
      pvic_pkg::ADDR_FLAGS:       rd_mux = cur_flags;
      pvic_pkg::ADDR_EVT_STATUS:  rd_mux = {28'h000_0000, evt_status_reg};
      pvic_pkg::ADDR_EVT_ENABLE:  rd_mux = {28'h000_0000, evt_enable_reg};
      pvic_pkg::ADDR_SAVED_FLAGS: rd_mux = saved_flags_reg;
      default:                    rd_mux = pvic_pkg::RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Next values of the flag bits
  // ----------------------------------------------------------------
  // Instruction effects take priority over a bus write in the same cycle
  logic if_next;
  logic vif_next;
  logic vip_next;
  logic v86_next;
  always_comb begin
    if_next  = if_reg;
    vif_next = vif_reg;
    vip_next = vip_reg;
    v86_next = v86_reg;
    if (wr_flags) begin
      if_next  = flags_new[pvic_pkg::POS_IF];
      vif_next = flags_new[pvic_pkg::POS_VIF];
      vip_next = flags_new[pvic_pkg::POS_VIP];
    end
    if (virt_write) begin
      vif_next = is_sti;
    end
    if (real_write) begin
      if_next = is_sti;
    end
    if (pop_if_ok) begin
      if_next = flags_load_i[pvic_pkg::POS_IF];
    end
    if (intr_return_instr_sup || is_tsw) begin
      vif_next = flags_load_i[pvic_pkg::POS_VIF];
      vip_next = flags_load_i[pvic_pkg::POS_VIP];
      if_next  = flags_load_i[pvic_pkg::POS_IF];
    end
    if (v86_enter) begin
      v86_next = 1'b1;
    end
    if (v86_exit) begin
      v86_next = 1'b0;
    end
  end

  // Privilege-changing calls have no path into the flag bits here

  wire logic [pvic_pkg::EVT_W-1:0] evt_set = {v86_exit, v86_enter, take_any, gp_event};
  wire logic [pvic_pkg::EVT_W-1:0] evt_clr = wr_clr ? clr_word[pvic_pkg::EVT_W-1:0] : 4'h0;
  wire logic [pvic_pkg::EVT_W-1:0] evt_next = (evt_status_reg & ~evt_clr) | evt_set;
  wire logic [pvic_pkg::EVT_W-1:0] en_next  = wr_en ? en_new[pvic_pkg::EVT_W-1:0] : evt_enable_reg;
  wire logic                       pvi_next = wr_ctrl ? ctrl_new[pvic_pkg::POS_PVI_ENABLE] : pvi_reg;

  // ----------------------------------------------------------------
  // Flag and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pvi_reg <= pvic_pkg::RST_PVI_ENABLE;
      if_reg  <= pvic_pkg::RST_IF;
      vif_reg <= pvic_pkg::RST_VIF;
      vip_reg <= pvic_pkg::RST_VIP;
      v86_reg <= pvic_pkg::RST_V86;
    end else begin
      pvi_reg <= pvi_next;
      if_reg  <= if_next;
      vif_reg <= vif_next;
      vip_reg <= vip_next;
      v86_reg <= v86_next;
    end
  end

  // Flags image kept across v86 entry and exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      saved_flags_reg <= pvic_pkg::RST_WORD;
    end else if (v86_enter || v86_exit) begin
      saved_flags_reg <= cur_flags;
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_reg <= pvic_pkg::RST_EVT;
      evt_enable_reg <= pvic_pkg::RST_EVT;
      irq_reg        <= 1'b0;
    end else begin
      evt_status_reg <= evt_next;
      evt_enable_reg <= en_next;
      irq_reg        <= |(evt_next & en_next);
    end
  end

  // ----------------------------------------------------------------
  // Core-facing pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gp_reg         <= 1'b0;
      deliv_reg      <= 1'b0;
      deliv_vec_reg  <= 8'h00;
      push_valid_reg <= 1'b0;
      push_data_reg  <= pvic_pkg::RST_WORD;
    end else begin
      gp_reg         <= gp_event;
      deliv_reg      <= take_any;
      deliv_vec_reg  <= take_any ? take_vec : deliv_vec_reg;
      push_valid_reg <= is_push_flags_instr;
      push_data_reg  <= is_push_flags_instr ? cur_flags : push_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= pvic_pkg::RST_WORD;
    end else begin
      ack_reg   <= wb_req;
      rdata_reg <= wb_req ? rd_mux : rdata_reg;
    end
  end

  assign wb_ack_o                   = ack_reg;
  assign wb_dat_o                   = rdata_reg;
  assign general_protection_fault_o = gp_reg;
  assign intr_deliver_o             = deliv_reg;
  assign intr_deliver_vector_o      = deliv_vec_reg;
  assign push_valid_o               = push_valid_reg;
  assign push_data_o                = push_data_reg;
  assign irq_o                      = irq_reg;

  // Flags view also comes from flip-flops only
  assign flags_register_o = pack_flags(if_reg, v86_reg, vif_reg, vip_reg);

endmodule : pvic_ctl

`default_nettype wire

/* pvic_ctl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module pvic_ctl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_valid_i,
  input wire logic [2:0]  instr_op_i,
  input wire logic [1:0]  current_privilege_level_i,
  input wire logic [1:0]  io_privilege_level_i,
  input wire logic        intr_req_i,
  input wire logic [7:0]  intr_vector_i,
  input wire logic        nmi_req_i,
  input wire logic        general_protection_fault_o,
  input wire logic        intr_deliver_o,
  input wire logic [7:0]  intr_deliver_vector_o,
  input wire logic        push_valid_o,
  input wire logic [31:0] push_data_o,
  input wire logic [31:0] flags_register_o
);
  logic pvi_reg;
  wire logic wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire logic flg_wr  = wr_take & (wb_adr_i == pvic_pkg::ADDR_FLAGS);
  wire logic set_op  = instr_valid_i & (instr_op_i == pvic_pkg::OP_SET_INT);
  wire logic ci      = ~flg_wr & (set_op | (instr_valid_i & (instr_op_i == pvic_pkg::OP_CLEAR_INT)));
  wire logic virt    = pvi_reg & (current_privilege_level_i == pvic_pkg::PL_USER)
                     & (io_privilege_level_i != pvic_pkg::PL_USER);
  wire logic legal   = current_privilege_level_i <= io_privilege_level_i;
  wire logic f_if    = flags_register_o[pvic_pkg::POS_IF];
  wire logic f_vif   = flags_register_o[pvic_pkg::POS_VIF];
  wire logic f_vip   = flags_register_o[pvic_pkg::POS_VIP];
  wire logic fault   = general_protection_fault_o;
  wire logic mreq    = intr_req_i & ~nmi_req_i & ~intr_deliver_o & (intr_vector_i >= pvic_pkg::VEC_MASKABLE_LO);

  // Tracks the enable bit of the control register from bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pvi_reg <= 1'b0;
    end else if (wr_take && wb_adr_i == pvic_pkg::ADDR_CTRL_FOUR && wb_sel_i[0]) begin
      pvi_reg <= wb_dat_i[pvic_pkg::POS_PVI_ENABLE];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_VIRT_CS : assert property (ci && virt && !(set_op && f_vip)
    |=> !fault && $stable(f_if) && f_vif == $past(set_op)) else $error("virtual clear or set wrong");
  AST_VIRT_PEND : assert property (ci && virt && set_op && f_vip |=> fault)
    else $error("pending set did not fault");
  AST_VIRT_SET : assert property (ci && virt && set_op && !f_vip |=> f_vif && !fault)
    else $error("set with nothing pending wrong");
  AST_LEGACY_FAULT : assert property (ci && !virt && !legal |=> fault && $stable(f_if))
    else $error("legacy privilege fault missing");
  AST_LEGACY_IF : assert property (ci && !virt && legal |=> !fault && f_if == $past(set_op))
    else $error("legacy enable flag wrong");
  AST_NMI : assert property (nmi_req_i && !intr_deliver_o
    |=> intr_deliver_o && intr_deliver_vector_o == pvic_pkg::VEC_NMI) else $error("nmi not delivered");
  AST_MASKABLE : assert property (mreq && f_if |=> intr_deliver_o && intr_deliver_vector_o == $past(intr_vector_i))
    else $error("maskable interrupt not delivered");
  AST_MASK_BLOCK : assert property (mreq && !f_if |=> !intr_deliver_o)
    else $error("masked interrupt delivered");
  AST_PUSH : assert property (instr_valid_i && instr_op_i == pvic_pkg::OP_PUSH_FLG
    |=> push_valid_o && push_data_o == $past(flags_register_o)) else $error("push image wrong");
  AST_CALL : assert property (instr_valid_i && instr_op_i == pvic_pkg::OP_CALL_PRIV && !flg_wr
    && !intr_req_i && !nmi_req_i |=> $stable(flags_register_o)) else $error("call changed flags");
endmodule : pvic_ctl_chk

bind pvic_ctl pvic_ctl_chk u_pvic_ctl_chk (.*);
`default_nettype wire

/* protected_virtual_interrupt_ctl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module protected_virtual_interrupt_ctl_test;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, intr_vector_i = 8'h00, intr_deliver_vector_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, flags_load_i = 32'h0000_0000, wb_dat_o, push_data_o, flags_register_o;
  logic        instr_valid_i = 1'b0, intr_req_i = 1'b0, nmi_req_i = 1'b0, wb_ack_o;
  logic [2:0]  instr_op_i = 3'h0;
  logic [1:0]  current_privilege_level_i = 2'h0, io_privilege_level_i = 2'h0;
  logic        general_protection_fault_o, intr_deliver_o, push_valid_o, irq_o;
  logic [31:0] r, rnd;
  int          miscompares = 0, checks = 0, m_pvi = 0, m_if = 0, m_vif = 0, m_vip = 0;
  integer      seed = 32'h4711;

  pvic_ctl u_pvic_ctl (.*);

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  function automatic logic [31:0] fw();
    return (32'(m_if) << pvic_pkg::POS_IF) | (32'(m_vif) << pvic_pkg::POS_VIF) | (32'(m_vip) << pvic_pkg::POS_VIP);
  endfunction : fw
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wf(input logic [31:0] d);
    bus(1'b1, pvic_pkg::ADDR_FLAGS, d, r);
    m_if  = d[pvic_pkg::POS_IF];
    m_vif = d[pvic_pkg::POS_VIF];
    m_vip = d[pvic_pkg::POS_VIP];
    bus(1'b0, pvic_pkg::ADDR_FLAGS, 32'h0000_0000, r);
    check(r, fw(), "flags readback");
  endtask : wf
  task automatic sp(input logic p);
    m_pvi = p;
    bus(1'b1, pvic_pkg::ADDR_CTRL_FOUR, {30'h0, p, 1'b0}, r);
    bus(1'b0, pvic_pkg::ADDR_CTRL_FOUR, 32'h0000_0000, r);
    check(r, {30'h0, p, 1'b0}, "ctrl readback");
  endtask : sp
  task automatic ins(input logic [2:0] op, input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    current_privilege_level_i <= current_privilege_level;
    io_privilege_level_i <= io_privilege_level;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : ins
  task automatic ld(input logic [2:0] op, input logic [1:0] current_privilege_level, input logic [31:0] fl);
    @(posedge clk_i);
    flags_load_i <= fl;
    ins(op, current_privilege_level, 2'h0);
  endtask : ld
  // Clear or set with the behavioural model
  task automatic cs(input logic st, input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
    int flt = 0;
    if (m_pvi != 0 && current_privilege_level == pvic_pkg::PL_USER && io_privilege_level != pvic_pkg::PL_USER) begin
      if (st && m_vip != 0) flt = 1;
      else m_vif = st;
    end else if (current_privilege_level > io_privilege_level) flt = 1;
    else m_if = st;
    ins(st ? pvic_pkg::OP_SET_INT : pvic_pkg::OP_CLEAR_INT, current_privilege_level, io_privilege_level);
    check(32'(general_protection_fault_o), flt, "fault");
    check(flags_register_o, fw(), "flags");
  endtask : cs
  task automatic it(input logic [7:0] v, input logic nmi, input logic exp, input logic [7:0] ev);
    @(posedge clk_i);
    intr_req_i <= 1'b1;
    intr_vector_i <= v;
    nmi_req_i <= nmi;
    @(posedge clk_i);
    intr_req_i <= 1'b0;
    nmi_req_i <= 1'b0;
    #1;
    check(32'(intr_deliver_o), 32'(exp), "deliver");
    if (exp) check(32'(intr_deliver_vector_o), 32'(ev), "vector");
  endtask : it
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(flags_register_o, 32'h0000_0000, "reset flags");
    bus(1'b0, 8'hFC, 32'h0000_0000, r);
    check(r, 32'h0000_0000, "unmapped read");
    sp(1'b1);
    wf(32'h0010_0000);
    cs(1'b1, 2'h3, 2'h0);
    wf(32'h0000_0000);
    cs(1'b1, 2'h3, 2'h0);
    cs(1'b0, 2'h3, 2'h1);
    wf(32'h0010_0000);
    cs(1'b1, 2'h0, 2'h0);
    it(8'h40, 1'b0, 1'b1, 8'h40);
    cs(1'b0, 2'h0, 2'h0);
    it(8'h40, 1'b0, 1'b0, 8'h00);
    it(8'h05, 1'b0, 1'b1, 8'h05);
    it(8'h40, 1'b1, 1'b1, pvic_pkg::VEC_NMI);
    ins(pvic_pkg::OP_PUSH_FLG, 2'h3, 2'h0);
    check(32'(push_valid_o), 32'h0000_0001, "push valid");
    check(push_data_o, fw(), "push data");
    ins(pvic_pkg::OP_CALL_PRIV, 2'h0, 2'h3);
    check(flags_register_o, fw(), "call flags");
    bus(1'b1, pvic_pkg::ADDR_EVT_ENABLE, 32'h0000_0001, r);
    bus(1'b1, pvic_pkg::ADDR_EVT_CLEAR, 32'h0000_000F, r);
    @(posedge clk_i);
    #1 check(32'(irq_o), 32'h0000_0000, "irq after clear");
    sp(1'b0);
    cs(1'b1, 2'h3, 2'h0);
    repeat (2) @(posedge clk_i);
    #1 check(32'(irq_o), 32'h0000_0001, "irq raised");
    bus(1'b0, pvic_pkg::ADDR_EVT_STATUS, 32'h0000_0000, r);
    check(r, 32'h0000_0001, "status");
    bus(1'b1, pvic_pkg::ADDR_EVT_ENABLE, 32'h0000_0000, r);
    @(posedge clk_i);
    #1 check(32'(irq_o), 32'h0000_0000, "irq masked");
    bus(1'b1, pvic_pkg::ADDR_EVT_CLEAR, 32'h0000_0001, r);
    bus(1'b0, pvic_pkg::ADDR_EVT_STATUS, 32'h0000_0000, r);
    check(r, 32'h0000_0000, "status cleared");
    ld(pvic_pkg::OP_POP_FLG, 2'h3, 32'h0000_0200);
    check(flags_register_o, fw(), "pop refused");
    ld(pvic_pkg::OP_POP_FLG, 2'h0, 32'h0000_0200);
    m_if = 1;
    check(flags_register_o, fw(), "pop flags");
    rnd = fw();
    ld(pvic_pkg::OP_TASK_SW, 2'h0, 32'h0002_0200);
    m_vip = 0;
    check(flags_register_o, fw() | 32'h0002_0000, "v86 entry");
    bus(1'b0, pvic_pkg::ADDR_SAVED_FLAGS, 32'h0000_0000, r);
    check(r, rnd, "saved at entry");
    cs(1'b1, 2'h3, 2'h0);
    bus(1'b0, pvic_pkg::ADDR_SAVED_FLAGS, 32'h0000_0000, r);
    check(r, fw() | 32'h0002_0000, "saved at exit");
    repeat (200) begin
      rnd = $random(seed);
      if (rnd[31:29] == 3'h0) wf($random(seed));
      if (rnd[28:26] == 3'h0) sp(rnd[25]);
      cs(rnd[0], rnd[2:1], rnd[4:3]);
    end
    close_out();
  end
  initial begin
    #(100 * 20000);
    miscompares++;
    close_out();
  end
endmodule : protected_virtual_interrupt_ctl_test
`default_nettype wire
